// [common/srtr_map.svh]
// Register offsets, field positions and reset values of the routing and buffer CSR block
`ifndef SRTR_MAP_SVH
`define SRTR_MAP_SVH

// ==========================================================================
// Register byte offsets
// ==========================================================================
`define SRTR_OFS_MAINT_INFO 32'h0000_0000
`define SRTR_OFS_BUF_CTRL 32'h0000_0004

// ==========================================================================
// Maintenance request information fields
// ==========================================================================
`define SRTR_MI_TID_MSB 31
`define SRTR_MI_TID_LSB 24
`define SRTR_MI_PRIO_MSB 18
`define SRTR_MI_PRIO_LSB 17
`define SRTR_MI_CRF_BIT 16
`define SRTR_MI_DEST_MSB 15
`define SRTR_MI_DEST_LSB 0
`define SRTR_MI_TID_RST 8'h00
`define SRTR_MI_PRIO_RST 2'h1
`define SRTR_MI_CRF_RST 1'h0
`define SRTR_MI_DEST_RST 16'h0000

// ==========================================================================
// Buffer control fields
// ==========================================================================
`define SRTR_BC_RXFC_ONLY_BIT 31
`define SRTR_BC_UNIFIED_BIT 30
`define SRTR_BC_TXFC_BIT 29
`define SRTR_BC_REORDER_BIT 28
`define SRTR_BC_TXSIZE_MSB 26
`define SRTR_BC_TXSIZE_LSB 16
`define SRTR_BC_FORCE_BIT 15
`define SRTR_BC_RXSIZE_MSB 7
`define SRTR_BC_RXSIZE_LSB 0

// ==========================================================================
// Transaction type codes
// ==========================================================================
`define SRTR_FT_REQ 4'h2
`define SRTR_FT_WRITE 4'h5
`define SRTR_FT_STREAM 4'h6
`define SRTR_TT_NREAD 4'h4
`define SRTR_TT_NWRITE 4'h4
`define SRTR_TT_NWRITE_R 4'h5

`endif

// [common/srtr_pkg.sv]
// Types shared by the routing and buffer CSR block
package srtr_pkg;

    // ======================================================================
    // Received transaction classes
    // ======================================================================
    typedef enum logic [2:0] {
        SRTR_KIND_NONE = 3'b000,
        SRTR_KIND_NREAD = 3'b001,
        SRTR_KIND_NWRITE = 3'b010,
        SRTR_KIND_NWRITE_R = 3'b011,
        SRTR_KIND_SWRITE = 3'b100
    } srtr_kind_type;

endpackage : srtr_pkg

// [common/srtr_link_if.sv]
// Interfaces between the top of the block and its decoder and maintenance store
`timescale 1ns/1ps

interface srtr_dec_if;
    import srtr_pkg::*;
    logic [3:0] ftype;
    logic [3:0] ttype;
    srtr_kind_type kind;
    logic supported;
    logic has_data;
    logic wants_resp;
    modport dec (input ftype, input ttype, output kind, output supported,
                 output has_data, output wants_resp);
    modport user (output ftype, output ttype, input kind, input supported,
                  input has_data, input wants_resp);
endinterface : srtr_dec_if

interface srtr_mi_if;
    logic wr_en;
    logic [31:0] wdata;
    logic send;
    logic [15:0] dest_id;
    logic [7:0] tid;
    logic [1:0] prio;
    logic crf;
    logic [31:0] rdata;
    modport store (input wr_en, input wdata, input send, output dest_id,
                   output tid, output prio, output crf, output rdata);
    modport user (output wr_en, output wdata, output send, input dest_id,
                  input tid, input prio, input crf, input rdata);
endinterface : srtr_mi_if

// [hw/srtr_decoder.sv]
// Combinational classifier of received transaction type codes
`timescale 1ns/1ps
`include "srtr_map.svh"

module srtr_decoder
    import srtr_pkg::*;
#(
    parameter bit SUP_NREAD = 1'b1,
    parameter bit SUP_NWRITE = 1'b1,
    parameter bit SUP_NWRITE_R = 1'b1,
    parameter bit SUP_SWRITE = 1'b1
)
(
    srtr_dec_if.dec d
);

    // Map format and transaction type onto a class and its properties
    always_comb
    begin
        d.kind = SRTR_KIND_NONE;
        d.supported = 1'b0;
        d.has_data = 1'b0;
        d.wants_resp = 1'b0;
        case (d.ftype)
            `SRTR_FT_REQ:
            begin
                if (d.ttype == `SRTR_TT_NREAD)
                begin
                    d.kind = SRTR_KIND_NREAD;
                    d.supported = SUP_NREAD;
                    d.wants_resp = 1'b1;
                end
            end
            `SRTR_FT_WRITE:
            begin
                if (d.ttype == `SRTR_TT_NWRITE)
                begin
                    d.kind = SRTR_KIND_NWRITE;
                    d.supported = SUP_NWRITE;
                    d.has_data = 1'b1;
                end
                else if (d.ttype == `SRTR_TT_NWRITE_R)
                begin
                    d.kind = SRTR_KIND_NWRITE_R;
                    d.supported = SUP_NWRITE_R;
                    d.has_data = 1'b1;
                    d.wants_resp = 1'b1;
                end
            end
            // Reduced header: ttype is not looked at
            `SRTR_FT_STREAM:
            begin
                d.kind = SRTR_KIND_SWRITE;
                d.supported = SUP_SWRITE;
                d.has_data = 1'b1;
            end
            default:
                d.kind = SRTR_KIND_NONE;
        endcase
    end

endmodule : srtr_decoder

// [hw/srtr_maint_info.sv]
// Maintenance request information store with self-incrementing transaction ID
`timescale 1ns/1ps
`include "srtr_map.svh"

module srtr_maint_info #(
    parameter bit CRF_SUPPORT = 1'b1
)
(
    input wire logic clock,
    input wire logic rst,
    srtr_mi_if.store mi
);

    logic [15:0] dest_id;
    logic [7:0] tid;
    logic [1:0] prio;
    logic crf;
    logic [15:0] next_dest_id;
    logic [7:0] next_tid;
    logic [1:0] next_prio;
    logic next_crf;

    // Next values; a software write wins over a send in the same cycle
    always_comb
    begin
        next_dest_id = dest_id;
        next_tid = tid;
        next_prio = prio;
        next_crf = crf;
        if (rst)
        begin
            next_dest_id = `SRTR_MI_DEST_RST;
            next_tid = `SRTR_MI_TID_RST;
            next_prio = `SRTR_MI_PRIO_RST;
            next_crf = `SRTR_MI_CRF_RST;
        end
        else if (mi.wr_en)
        begin
            next_dest_id = mi.wdata[`SRTR_MI_DEST_MSB:`SRTR_MI_DEST_LSB];
            next_tid = mi.wdata[`SRTR_MI_TID_MSB:`SRTR_MI_TID_LSB];
            next_prio = mi.wdata[`SRTR_MI_PRIO_MSB:`SRTR_MI_PRIO_LSB];
            // Without CRF support the bit stays at its reset value
            next_crf = CRF_SUPPORT ? mi.wdata[`SRTR_MI_CRF_BIT] : `SRTR_MI_CRF_RST;
        end
        else if (mi.send)
        begin
            next_tid = tid + 8'h01;
        end
    end

    // State registers
    always_ff @(posedge clock)
    begin
        dest_id <= next_dest_id;
        tid <= next_tid;
        prio <= next_prio;
        crf <= next_crf;
    end

    // Fields towards the request builder and the read path
    assign mi.dest_id = dest_id;
    assign mi.tid = tid;
    assign mi.prio = prio;
    assign mi.crf = crf;
    assign mi.rdata = {tid, 5'h00, prio, crf, dest_id};

endmodule : srtr_maint_info

// [hw/srtr_top.sv]
// Buffer_control_status, maintenance request information and transaction routing
`timescale 1ns/1ps
`include "srtr_map.svh"


module srtr_top
    import srtr_pkg::*;
#(
    parameter bit RX_FC_ONLY = 1'b0,
    parameter bit UNIFIED_CLOCK = 1'b0,
    parameter bit TX_REORDER = 1'b0,
    parameter bit FORCE_RX_FC_RESET = 1'b0,
    parameter bit CRF_SUPPORT = 1'b1,
    parameter bit COMBINED_IO = 1'b0,
    parameter bit USER_PORT = 1'b1,
    parameter bit SUP_NREAD = 1'b1,
    parameter bit SUP_NWRITE = 1'b1,
    parameter bit SUP_NWRITE_R = 1'b1,
    parameter bit SUP_SWRITE = 1'b1,
    parameter int TX_SIZE = 32,
    parameter int RX_SIZE = 32
)
(
    input wire logic clock,
    input wire logic rst,
    // Register access
    input wire logic reg_req,
    input wire logic reg_wr,
    input wire logic [31:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic reg_ack,
    output logic reg_err,
    output logic [31:0] reg_rdata,
    // Flow control state from the lane layer unit
    input wire logic partner_tx_fc,
    output logic tx_fc_active,
    // Outgoing maintenance request fields
    input wire logic maint_send,
    output logic [15:0] maint_dest_id,
    output logic [7:0] maint_tid,
    output logic [1:0] maint_prio,
    output logic maint_crf,
    // Outgoing request steering
    input wire logic tx_req_valid,
    output logic tx_to_io,
    output logic tx_to_ireq,
    // Received request steering
    input wire logic rx_hdr_valid,
    input wire logic [3:0] rx_ftype,
    input wire logic [3:0] rx_ttype,
    output logic rx_to_io,
    output logic rx_to_treq,
    output logic rx_to_user,
    output srtr_kind_type rx_kind,
    output logic rx_has_data,
    output logic rx_wants_resp,
    output logic unroutable_error
);

    // ======================================================================
    // Build option checks
    // ======================================================================
    // The size fields only encode the three depths the buffers come in
    if (!(TX_SIZE == 8 || TX_SIZE == 16 || TX_SIZE == 32)
        || !(RX_SIZE == 8 || RX_SIZE == 16 || RX_SIZE == 32))
    begin : g_bad_size
        $error("TX_SIZE and RX_SIZE must be 8, 16 or 32");
    end

    localparam logic [10:0] TX_SIZE_FIELD = 11'(TX_SIZE);
    localparam logic [7:0] RX_SIZE_FIELD = 8'(RX_SIZE);

    // ======================================================================
    // Submodules
    // ======================================================================
    srtr_mi_if mi ();
    srtr_dec_if dec ();

    srtr_maint_info #(
        .CRF_SUPPORT(CRF_SUPPORT)
    ) u_maint_info (
        .clock(clock),
        .rst(rst),
        .mi(mi.store)
    );

    srtr_decoder #(
        .SUP_NREAD(SUP_NREAD),
        .SUP_NWRITE(SUP_NWRITE),
        .SUP_NWRITE_R(SUP_NWRITE_R),
        .SUP_SWRITE(SUP_SWRITE)
    ) u_decoder (
        .d(dec.dec)
    );

    // ======================================================================
    // Register decode
    // ======================================================================
    logic hit_mi;
    logic hit_bc;
    logic wr_bc;
    logic [31:0] bc_word;
    logic force_rx_fc;
    logic next_force_rx_fc;
    logic next_tx_fc_active;

    // Only this port writes the maintenance store; maint_send just steps its ID
    assign hit_mi = reg_req && (reg_addr == `SRTR_OFS_MAINT_INFO);
    assign hit_bc = reg_req && (reg_addr == `SRTR_OFS_BUF_CTRL);
    assign wr_bc = hit_bc && reg_wr;
    assign mi.wr_en = hit_mi && reg_wr;
    assign mi.wdata = reg_wdata;
    assign mi.send = maint_send;

    // ======================================================================
    // Buffer control state
    // ======================================================================
    // Force bit and live flow-control mode
    always_comb
    begin
        next_force_rx_fc = force_rx_fc;
        next_tx_fc_active = tx_fc_active;
        if (rst)
        begin
            next_force_rx_fc = FORCE_RX_FC_RESET;
            next_tx_fc_active = 1'b0;
        end
        else
        begin
            // A receiver-only build has nothing to force, so writes are dropped
            if (wr_bc && !RX_FC_ONLY)
                next_force_rx_fc = reg_wdata[`SRTR_BC_FORCE_BIT];
            // Transmitter mode needs the build, the partner and no force
            next_tx_fc_active = !RX_FC_ONLY && !force_rx_fc && partner_tx_fc;
        end
    end

    // Flow control registers
    always_ff @(posedge clock)
    begin
        force_rx_fc <= next_force_rx_fc;
        tx_fc_active <= next_tx_fc_active;
    end

    // Read view of the buffer control word; reserved bits read zero
    always_comb
    begin
        bc_word = 32'h0000_0000;
        bc_word[`SRTR_BC_RXFC_ONLY_BIT] = RX_FC_ONLY;
        bc_word[`SRTR_BC_UNIFIED_BIT] = UNIFIED_CLOCK;
        bc_word[`SRTR_BC_TXFC_BIT] = tx_fc_active;
        bc_word[`SRTR_BC_REORDER_BIT] = TX_REORDER;
        bc_word[`SRTR_BC_TXSIZE_MSB:`SRTR_BC_TXSIZE_LSB] = TX_SIZE_FIELD;
        bc_word[`SRTR_BC_FORCE_BIT] = force_rx_fc;
        bc_word[`SRTR_BC_RXSIZE_MSB:`SRTR_BC_RXSIZE_LSB] = RX_SIZE_FIELD;
    end

    // ======================================================================
    // Register answer
    // ======================================================================
    logic next_reg_ack;
    logic next_reg_err;
    logic [31:0] next_reg_rdata;

    // One answer per request, one cycle later; unmapped reads return zero
    always_comb
    begin
        next_reg_ack = 1'b0;
        next_reg_err = 1'b0;
        next_reg_rdata = 32'h0000_0000;
        if (!rst && reg_req)
        begin
            next_reg_ack = 1'b1;
            if (hit_mi)
                next_reg_rdata = mi.rdata;
            else if (hit_bc)
                next_reg_rdata = bc_word;
            else
                next_reg_err = 1'b1;
        end
    end

    // Register answer flops
    always_ff @(posedge clock)
    begin
        reg_ack <= next_reg_ack;
        reg_err <= next_reg_err;
        reg_rdata <= next_reg_rdata;
    end

    // ======================================================================
    // Maintenance request fields
    // ======================================================================
    // Straight from the store's flops: a send shows the next ID one cycle later,
    // unless a software write in the same cycle loads the ID from the written word
    assign maint_dest_id = mi.dest_id;
    assign maint_tid = mi.tid;
    assign maint_prio = mi.prio;
    assign maint_crf = mi.crf;

    // ======================================================================
    // Outgoing request steering
    // ======================================================================
    logic next_tx_to_io;
    logic next_tx_to_ireq;

    // Port style is fixed at build time, so only one strobe ever moves
    always_comb
    begin
        next_tx_to_io = 1'b0;
        next_tx_to_ireq = 1'b0;
        if (!rst && tx_req_valid)
        begin
            next_tx_to_io = COMBINED_IO;
            next_tx_to_ireq = !COMBINED_IO;
        end
    end

    // Outgoing strobe flops
    always_ff @(posedge clock)
    begin
        tx_to_io <= next_tx_to_io;
        tx_to_ireq <= next_tx_to_ireq;
    end

    // ======================================================================
    // Received request steering
    // ======================================================================
    logic next_rx_to_io;
    logic next_rx_to_treq;
    logic next_rx_to_user;
    logic next_unroutable_error;
    srtr_kind_type next_rx_kind;
    logic next_rx_has_data;
    logic next_rx_wants_resp;

    assign dec.ftype = rx_ftype;
    assign dec.ttype = rx_ttype;

    // Classify each header and pick exactly one destination or the drop path
    always_comb
    begin
        next_rx_to_io = 1'b0;
        next_rx_to_treq = 1'b0;
        next_rx_to_user = 1'b0;
        next_unroutable_error = 1'b0;
        next_rx_kind = rx_kind;
        next_rx_has_data = rx_has_data;
        next_rx_wants_resp = rx_wants_resp;
        if (rst)
        begin
            next_rx_kind = SRTR_KIND_NONE;
            next_rx_has_data = 1'b0;
            next_rx_wants_resp = 1'b0;
        end
        else if (rx_hdr_valid)
        begin
            next_rx_kind = dec.kind;
            next_rx_has_data = dec.has_data;
            next_rx_wants_resp = dec.wants_resp;
            if (dec.supported)
            begin
                next_rx_to_io = COMBINED_IO;
                next_rx_to_treq = !COMBINED_IO;
            end
            else if (USER_PORT)
                next_rx_to_user = 1'b1;
            else
            begin
                // Dropped here; the pulse and the latched rx_kind, rx_has_data and rx_wants_resp are all it leaves
                next_unroutable_error = 1'b1;
            end
        end
    end

    // Received steering flops
    always_ff @(posedge clock)
    begin
        rx_to_io <= next_rx_to_io;
        rx_to_treq <= next_rx_to_treq;
        rx_to_user <= next_rx_to_user;
        unroutable_error <= next_unroutable_error;
        rx_kind <= next_rx_kind;
        rx_has_data <= next_rx_has_data;
        rx_wants_resp <= next_rx_wants_resp;
    end

endmodule : srtr_top

// [test/srtr_chk.sv]
// Concurrent property checker bound to the routing and buffer CSR top
`timescale 1ns/1ps

module srtr_chk
    import srtr_pkg::*;
#(
    parameter bit RX_FC_ONLY = 1'b0,
    parameter bit UNIFIED_CLOCK = 1'b0,
    parameter bit TX_REORDER = 1'b0,
    parameter bit COMBINED_IO = 1'b0,
    parameter bit USER_PORT = 1'b1,
    parameter int TX_SIZE = 32,
    parameter int RX_SIZE = 32
)
(
    input wire logic clock,
    input wire logic rst,
    input wire logic reg_req,
    input wire logic reg_wr,
    input wire logic [31:0] reg_addr,
    input wire logic reg_ack,
    input wire logic reg_err,
    input wire logic [31:0] reg_rdata,
    input wire logic partner_tx_fc,
    input wire logic tx_fc_active,
    input wire logic maint_send,
    input wire logic [7:0] maint_tid,
    input wire logic tx_req_valid,
    input wire logic tx_to_io,
    input wire logic tx_to_ireq,
    input wire logic rx_hdr_valid,
    input wire logic [3:0] rx_ftype,
    input wire logic [3:0] rx_ttype,
    input wire logic rx_to_io,
    input wire logic rx_to_treq,
    input wire logic rx_to_user,
    input wire srtr_kind_type rx_kind,
    input wire logic rx_has_data,
    input wire logic rx_wants_resp,
    input wire logic unroutable_error
);
    // ======================================================================
    // Helper decode
    // ======================================================================
    logic known;
    logic mi_wr;
    // Unknown codes are unsupported whatever the build options
    assign known = (rx_ftype == 4'h2 && rx_ttype == 4'h4) || rx_ftype == 4'h6
        || (rx_ftype == 4'h5 && rx_ttype[3:1] == 3'h2);
    assign mi_wr = reg_req && reg_wr && reg_addr == 32'h0000_0000;

    // ======================================================================
    // Properties
    // ======================================================================
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_reg_ack;
        reg_req |=> reg_ack;
    endproperty
    a_reg_ack: assert property (p_reg_ack) else $error("request not answered");
    property p_unmapped;
        reg_req && reg_addr != 32'h0000_0000 && reg_addr != 32'h0000_0004
            |=> reg_err && reg_rdata == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access taken");
    property p_buf_word;
        reg_req && !reg_wr && reg_addr == 32'h0000_0004 |=> reg_rdata[31] == RX_FC_ONLY
            && reg_rdata[30] == UNIFIED_CLOCK && reg_rdata[28] == TX_REORDER
            && reg_rdata[26:16] == TX_SIZE[10:0] && reg_rdata[7:0] == RX_SIZE[7:0];
    endproperty
    a_buf_word: assert property (p_buf_word) else $error("build fields wrong");
    property p_fc_off;
        !partner_tx_fc || RX_FC_ONLY |=> !tx_fc_active;
    endproperty
    a_fc_off: assert property (p_fc_off) else $error("tx flow control wrong");
    property p_tid_step;
        maint_send && !mi_wr |=> maint_tid == $past(maint_tid) + 8'h01;
    endproperty
    a_tid_step: assert property (p_tid_step) else $error("id did not step");
    property p_tx_route;
        tx_req_valid |=> tx_to_io == COMBINED_IO && tx_to_ireq == !COMBINED_IO;
    endproperty
    a_tx_route: assert property (p_tx_route) else $error("request misrouted");
    property p_rx_one;
        rx_hdr_valid |=> $onehot({rx_to_io, rx_to_treq, rx_to_user, unroutable_error});
    endproperty
    a_rx_one: assert property (p_rx_one) else $error("header not routed once");
    property p_rx_unsup;
        rx_hdr_valid && !known |=> (USER_PORT ? rx_to_user : unroutable_error)
            && rx_kind == SRTR_KIND_NONE;
    endproperty
    a_rx_unsup: assert property (p_rx_unsup) else $error("unsupported misrouted");
    property p_nwrite;
        rx_hdr_valid && rx_ftype == 4'h5 && rx_ttype == 4'h4
            |=> rx_kind == SRTR_KIND_NWRITE && rx_has_data && !rx_wants_resp;
    endproperty
    a_nwrite: assert property (p_nwrite) else $error("write misclassified");
    property p_nwrite_r;
        rx_hdr_valid && rx_ftype == 4'h5 && rx_ttype == 4'h5
            |=> rx_kind == SRTR_KIND_NWRITE_R && rx_has_data && rx_wants_resp;
    endproperty
    a_nwrite_r: assert property (p_nwrite_r) else $error("response write misclassified");
    property p_swrite;
        rx_hdr_valid && rx_ftype == 4'h6
            |=> rx_kind == SRTR_KIND_SWRITE && rx_has_data && !rx_wants_resp;
    endproperty
    a_swrite: assert property (p_swrite) else $error("stream write misclassified");
endmodule : srtr_chk

bind srtr_top srtr_chk #(.RX_FC_ONLY(RX_FC_ONLY), .UNIFIED_CLOCK(UNIFIED_CLOCK),
    .TX_REORDER(TX_REORDER), .COMBINED_IO(COMBINED_IO), .USER_PORT(USER_PORT),
    .TX_SIZE(TX_SIZE), .RX_SIZE(RX_SIZE)) u_srtr_chk (.*);

// [test/srtr_user_model.sv]
// Model of the user logic on the request and header steering ports
`timescale 1ns/1ps

module srtr_user_model
(
    input wire logic clock,
    input wire logic rst,
    input wire logic go_tx,
    output logic tx_req_valid,
    input wire logic rx_to_io,
    input wire logic rx_to_treq,
    input wire logic rx_to_user,
    output logic [7:0] rx_count
);
    // Request strobe follows the command, which only moves just after an edge
    assign tx_req_valid = go_tx;
    // Count headers handed to any user port; a lost strobe shows as a short count
    always_ff @(posedge clock)
    begin
        if (rst)
            rx_count <= 8'h00;
        else if (rx_to_io || rx_to_treq || rx_to_user)
            rx_count <= rx_count + 8'h01;
    end
endmodule : srtr_user_model

// [test/tb_top.sv]
// Self-checking bench for the routing and buffer CSR top
`timescale 1ns/1ps

module tb_top
    import srtr_pkg::*;
;
    // ======================================================================
    // Signals and table of received headers
    // ======================================================================
    typedef struct packed {
        logic [3:0] ft;
        logic [3:0] tt;
        srtr_kind_type kind;
        logic [1:0] dr;
        logic [3:0] route;
    } srtr_row_type;
    logic clock, rst, reg_req, reg_wr, reg_ack, reg_err, partner_tx_fc, tx_fc_active;
    logic maint_send, maint_crf, tx_req_valid, tx_to_io, tx_to_ireq, rx_hdr_valid, go_tx;
    logic rx_to_io, rx_to_treq, rx_to_user, rx_has_data, rx_wants_resp, unroutable_error;
    logic [31:0] reg_addr, reg_wdata, reg_rdata, rdata;
    logic [15:0] maint_dest_id;
    logic [7:0] maint_tid, rx_count;
    logic [1:0] maint_prio;
    logic [3:0] rx_ftype, rx_ttype;
    logic err;
    srtr_kind_type rx_kind;
    int mismatches = 0;
    int checks_done = 0;
    // Route bits are io, target, user-defined, dropped
    srtr_row_type rows [8] = '{
        '{4'h2, 4'h4, SRTR_KIND_NREAD, 2'h1, 4'h4}, '{4'h5, 4'h4, SRTR_KIND_NWRITE, 2'h2, 4'h4},
        '{4'h5, 4'h5, SRTR_KIND_NWRITE_R, 2'h3, 4'h4}, '{4'h6, 4'h0, SRTR_KIND_SWRITE, 2'h2, 4'h4},
        '{4'h6, 4'hF, SRTR_KIND_SWRITE, 2'h2, 4'h4}, '{4'h5, 4'h0, SRTR_KIND_NONE, 2'h0, 4'h2},
        '{4'h8, 4'h0, SRTR_KIND_NONE, 2'h0, 4'h2}, '{4'h2, 4'h5, SRTR_KIND_NONE, 2'h0, 4'h2}};

    srtr_top u_srtr_top (.clock(clock), .rst(rst), .reg_req(reg_req), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_ack(reg_ack), .reg_err(reg_err),
        .reg_rdata(reg_rdata), .partner_tx_fc(partner_tx_fc), .tx_fc_active(tx_fc_active),
        .maint_send(maint_send), .maint_dest_id(maint_dest_id), .maint_tid(maint_tid),
        .maint_prio(maint_prio), .maint_crf(maint_crf), .tx_req_valid(tx_req_valid),
        .tx_to_io(tx_to_io), .tx_to_ireq(tx_to_ireq), .rx_hdr_valid(rx_hdr_valid),
        .rx_ftype(rx_ftype), .rx_ttype(rx_ttype), .rx_to_io(rx_to_io), .rx_to_treq(rx_to_treq),
        .rx_to_user(rx_to_user), .rx_kind(rx_kind), .rx_has_data(rx_has_data),
        .rx_wants_resp(rx_wants_resp), .unroutable_error(unroutable_error));
    srtr_user_model u_srtr_user_model (.clock(clock), .rst(rst), .go_tx(go_tx),
        .tx_req_valid(tx_req_valid), .rx_to_io(rx_to_io), .rx_to_treq(rx_to_treq),
        .rx_to_user(rx_to_user), .rx_count(rx_count));

    // ======================================================================
    // Tasks
    // ======================================================================
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One register cycle; the answer is due exactly one edge after the request
    task automatic reg_op(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
        @(posedge clock);
        #1;
        reg_req = 1'b1;
        reg_wr = wr;
        reg_addr = addr;
        reg_wdata = wd;
        @(posedge clock);
        #1;
        reg_req = 1'b0;
        rdata = reg_rdata;
        err = reg_err;
        chk(reg_ack, 1'b1);
    endtask : reg_op
    task automatic rd_chk(input logic [31:0] addr, input logic [31:0] exp);
        reg_op(1'b0, addr, 32'h0000_0000);
        chk(rdata, exp);
    endtask : rd_chk
    task automatic cycles(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cycles
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : finish_test

    // ======================================================================
    // Clock, watchdog and main sequence
    // ======================================================================
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // Work is under 150 cycles; the cap only cuts a hang short
    initial
    begin
        repeat (3000) @(posedge clock);
        mismatches++;
        finish_test;
    end
    initial
    begin
        {reg_req, reg_wr, maint_send, rx_hdr_valid, partner_tx_fc, go_tx} = '0;
        {reg_addr, reg_wdata, rx_ftype, rx_ttype} = '0;
        rst = 1'b1;
        cycles(8);
        rst = 1'b0;
        rd_chk(32'h0000_0000, 32'h0002_0000);
        rd_chk(32'h0000_0004, 32'h0020_0020);
        foreach (rows[i])
        begin
            cycles(1);
            rx_hdr_valid = 1'b1;
            rx_ftype = rows[i].ft;
            rx_ttype = rows[i].tt;
            cycles(1);
            rx_hdr_valid = 1'b0;
            chk({rx_to_io, rx_to_treq, rx_to_user, unroutable_error}, rows[i].route);
            chk(rx_kind, rows[i].kind);
            if (rows[i].kind != SRTR_KIND_NONE)
                chk({rx_has_data, rx_wants_resp}, rows[i].dr);
        end
        // Read-only build bits must survive a write of all ones
        reg_op(1'b1, 32'h0000_0004, 32'hFFFF_FFFF);
        chk(rx_count, 8'h08);
        rd_chk(32'h0000_0004, 32'h0020_8020);
        partner_tx_fc = 1'b1;
        cycles(2);
        chk(tx_fc_active, 1'b0);
        reg_op(1'b1, 32'h0000_0004, 32'h0000_0000);
        cycles(2);
        chk(tx_fc_active, 1'b1);
        rd_chk(32'h0000_0004, 32'h2020_0020);
        // Reserved bits are written as ones and must read back as zero
        reg_op(1'b1, 32'h0000_0000, 32'hFEFF_1234);
        rd_chk(32'h0000_0000, 32'hFE07_1234);
        chk({maint_tid, maint_prio, maint_crf, maint_dest_id}, 32'h07F7_1234);
        // Two sends back to back carry the identifier across its wrap
        maint_send = 1'b1;
        cycles(2);
        maint_send = 1'b0;
        cycles(2);
        chk(maint_tid, 8'h00);
        rd_chk(32'h0000_0000, 32'h0007_1234);
        go_tx = 1'b1;
        cycles(1);
        go_tx = 1'b0;
        chk({tx_to_io, tx_to_ireq}, 2'h1);
        reg_op(1'b1, 32'h0000_0008, 32'hFFFF_FFFF);
        chk(err, 1'b1);
        chk(rdata, 32'h0000_0000);
        rd_chk(32'h0000_0000, 32'h0007_1234);
        // A second reset in mid-run restores the information word
        rst = 1'b1;
        cycles(2);
        rst = 1'b0;
        rd_chk(32'h0000_0000, 32'h0002_0000);
        chk(rx_kind, SRTR_KIND_NONE);
        finish_test;
    end
endmodule : tb_top
